// >>> core/limit_pkg.sv
// Shared constants for the current and temperature limit register block.
// What this block does
// - Current warning register exponent bits 15:11 are read-only zero, one ampere per step.
// - Bits 10:6 of both limit registers are reserved and read as zero, except bits 8:6 of a broadcast current read.
// - Current warning bits 5:0 select the averaged output current warning threshold.
// - Any mantissa is stored and read back; hardware applies the nearest supported level.
// - A nonvolatile load restores a fixed mantissa code for each supported level.
// - Writes changing read-only bits 15:6 (only 15:11 on a split broadcast write) are refused, discarded, and raise cml and ivd flags.
// - Current mantissa bins to 5 A steps: below 8 is 5 A, 53 up is 55 A.
// - Broadcast write, two phases: add one, shift right one, then bin as phase level.
// - Broadcast write, four phases: add two, shift right two, then bin as phase level.
// - Broadcast write, three phases: stack level goes through its own lookup table.
// - Broadcast current read: only the primary answers, with phase level times stack size.
// - A digital comparator checks die temperature against the selected fault threshold.
// - Temperature limit exponent is read-only 00010b, four degrees per step.
// - Temperature bits 5:0 select the fault threshold; default restores 145 degrees.
// - Temperature mantissa bins: below 30 is 115 C, 37 up is 150 C.
// - Warn when averaged output current exceeds the binned warning threshold.
// - A temperature fault sets the temperature fault flag and raises the alert line.
package limit_pkg;

  localparam logic [7:0] CMD_OCW_LIMIT = 8'h4A;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4F;
  localparam logic [7:0] PHASE_ALL = 8'hFF;

  localparam int EXP_LSB = 11;
  localparam int RSV_LSB = 6;
  localparam int MANT_W = 6;
  localparam int STACK_LVL_W = 11;
  localparam logic [4:0] OCW_EXP = 5'h00;
  localparam logic [4:0] OT_EXP = 5'h02;
  localparam logic [4:0] RSV_VAL = 5'h00;

  localparam logic [5:0] OCW_RST_CODE = 6'h1E;
  localparam logic [5:0] OT_RST_CODE = 6'h24;

  localparam int OCW_LEVELS = 11;
  localparam int OT_LEVELS = 8;
  localparam int OCW_STEP_A = 5;

  // Lower bounds of every level above the lowest, packed 11 bits each, lowest bound in the low slice.
  localparam logic [10*11-1:0] OCW_BOUNDS = {11'd53, 11'd48, 11'd43, 11'd38, 11'd33,
                                             11'd28, 11'd23, 11'd18, 11'd13, 11'd8};
  localparam logic [10*11-1:0] OCW3_BOUNDS = {11'd158, 11'd143, 11'd128, 11'd113, 11'd98,
                                              11'd83, 11'd68, 11'd53, 11'd38, 11'd23};
  localparam logic [7*11-1:0] OT_BOUNDS = {11'd37, 11'd36, 11'd35, 11'd34, 11'd32, 11'd31, 11'd30};

  localparam logic [7:0] OT_DEGC [OT_LEVELS] = '{8'h73, 8'h78, 8'h7D, 8'h82, 8'h87, 8'h8C, 8'h91, 8'h96};
  localparam logic [5:0] OT_RESTORE [OT_LEVELS] = '{6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h22, 6'h23, 6'h24, 6'h25};

  function automatic logic [5:0] ocw_amps(input logic [3:0] lvl);
    ocw_amps = 6'((lvl + 4'h1) * OCW_STEP_A);
  endfunction

endpackage

// >>> core/level_binner.sv
// Maps a value onto a level index by counting the level bounds it has reached.
`timescale 1ns/1ps
module level_binner #(
  parameter int N = 10,
  parameter int W = 11,
  parameter int LW = 4,
  parameter logic [N*W-1:0] BOUNDS = '0
) (
  input wire logic [W-1:0] i_value,
  output logic [LW-1:0] o_level
);

  logic [N-1:0] reached;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bound
      assign reached[g] = (i_value >= BOUNDS[g*W +: W]);
    end
  endgenerate

  // Bounds rise with the index, so the count of reached bounds is the level.
  always_comb begin
    o_level = '0;
    for (int k = 0; k < N; k++) begin
      o_level = o_level + LW'(reached[k]);
    end
  end

endmodule // level_binner

// >>> core/limit_regs.sv
// Current warning and die temperature fault limit registers with their comparators.
`timescale 1ns/1ps
module limit_regs
  import limit_pkg::*;
#(
  parameter int IOUT_W = 8,
  parameter int TEMP_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_phase,
  input wire logic [15:0] i_wr_data,
  input wire logic [2:0] i_stack_number,
  input wire logic i_primary,
  input wire logic i_nvm_load,
  input wire logic [3:0] i_nvm_ocw_level,
  input wire logic [2:0] i_nvm_ot_level,
  input wire logic i_cml_clr,
  input wire logic i_temp_flag_clr,
  input wire logic [IOUT_W-1:0] i_iout_avg,
  input wire logic [TEMP_W-1:0] i_die_temp,
  output logic o_wr_ack,
  output logic o_wr_nack,
  output logic o_rd_valid,
  output logic o_rd_silent,
  output logic [15:0] o_rd_data,
  output logic [5:0] o_ocw_amps,
  output logic [7:0] o_ot_degc,
  output logic o_ocw_warn,
  output logic o_ot_fault,
  output logic o_cml_flag,
  output logic o_ivd_flag,
  output logic o_temp_fault_flag,
  output logic o_alert
);

  // Decode of the incoming transaction.
  wire logic is_ocw = (i_cmd == CMD_OCW_LIMIT);
  wire logic is_ot = (i_cmd == CMD_OT_LIMIT);
  wire logic bcast = (i_phase == PHASE_ALL);
  wire logic stack_multi = (i_stack_number > 3'd1);
  wire logic split_wr = is_ocw & bcast & stack_multi;

  wire logic [4:0] wr_exp = i_wr_data[15:EXP_LSB];
  wire logic [4:0] wr_rsv = i_wr_data[EXP_LSB-1:RSV_LSB];
  wire logic [5:0] wr_mant = i_wr_data[MANT_W-1:0];
  wire logic [STACK_LVL_W-1:0] stack_lvl = i_wr_data[STACK_LVL_W-1:0];

  // A split write carries a stack level wider than the mantissa, so only its exponent is checked.
  wire logic ocw_fixed_ok = split_wr ? (wr_exp == OCW_EXP) :
                            ((wr_exp == OCW_EXP) && (wr_rsv == RSV_VAL));
  wire logic ot_fixed_ok = (wr_exp == OT_EXP) && (wr_rsv == RSV_VAL);
  wire logic wr_ok = is_ocw ? ocw_fixed_ok : ot_fixed_ok;
  wire logic wr_hit = i_wr_stb & (is_ocw | is_ot);
  wire logic wr_take = wr_hit & wr_ok;
  wire logic wr_refuse = wr_hit & ~wr_ok;

  // Stack level divided among phases, rounded to nearest with halves up.
  wire logic [11:0] stack_plus1 = {1'b0, stack_lvl} + 12'h001;
  wire logic [11:0] stack_plus2 = {1'b0, stack_lvl} + 12'h002;
  wire logic [10:0] phase_half = stack_plus1[11:1];
  wire logic [10:0] phase_quarter = {1'b0, stack_plus2[11:2]};
  wire logic [10:0] phase_lvl = (i_stack_number == 3'd4) ? phase_quarter : phase_half;

  logic [5:0] ocw_code_r;
  logic [5:0] ocw_code_nxt;
  logic [5:0] ot_code_r;
  logic [5:0] ot_code_nxt;
  logic [3:0] ocw_lvl;
  logic [3:0] split_lvl;
  logic [3:0] split3_lvl;
  logic [2:0] ot_lvl;

  // The applied current level always follows the stored mantissa.
  level_binner #(
    .N(OCW_LEVELS - 1),
    .W(11),
    .LW(4),
    .BOUNDS(OCW_BOUNDS)
  ) u_ocw_apply (
    .i_value({5'h00, ocw_code_r}),
    .o_level(ocw_lvl)
  );

  level_binner #(
    .N(OCW_LEVELS - 1),
    .W(11),
    .LW(4),
    .BOUNDS(OCW_BOUNDS)
  ) u_ocw_split (
    .i_value(phase_lvl),
    .o_level(split_lvl)
  );

  level_binner #(
    .N(OCW_LEVELS - 1),
    .W(11),
    .LW(4),
    .BOUNDS(OCW3_BOUNDS)
  ) u_ocw_split3 (
    .i_value(stack_lvl),
    .o_level(split3_lvl)
  );

  level_binner #(
    .N(OT_LEVELS - 1),
    .W(11),
    .LW(3),
    .BOUNDS(OT_BOUNDS)
  ) u_ot_apply (
    .i_value({5'h00, ot_code_r}),
    .o_level(ot_lvl)
  );

  // Split writes store the fixed restore code of the binned level so the readback matches hardware.
  wire logic [3:0] split_sel = (i_stack_number == 3'd3) ? split3_lvl : split_lvl;
  wire logic [5:0] split_code = ocw_amps(split_sel);

  // Nonvolatile loads carry a level index; out-of-range indices saturate at the top level.
  wire logic [3:0] nvm_ocw_sat = (i_nvm_ocw_level > 4'(OCW_LEVELS - 1)) ? 4'(OCW_LEVELS - 1) : i_nvm_ocw_level;
  wire logic [5:0] nvm_ocw_code = ocw_amps(nvm_ocw_sat);
  wire logic [5:0] nvm_ot_code = OT_RESTORE[i_nvm_ot_level];

  always_comb begin
    ocw_code_nxt = ocw_code_r;
    if (wr_take && is_ocw) begin
      ocw_code_nxt = split_wr ? split_code : wr_mant;
    end else if (i_nvm_load) begin
      ocw_code_nxt = nvm_ocw_code;
    end
  end

  always_comb begin
    ot_code_nxt = ot_code_r;
    if (wr_take && is_ot) begin
      ot_code_nxt = wr_mant;
    end else if (i_nvm_load) begin
      ot_code_nxt = nvm_ot_code;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ocw_code_r <= OCW_RST_CODE;
      ot_code_r <= OT_RST_CODE;
    end else begin
      ocw_code_r <= ocw_code_nxt;
      ot_code_r <= ot_code_nxt;
    end
  end

  // Write answers, one cycle after the strobe.
  logic wr_ack_r;
  logic wr_nack_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ack_r <= 1'b0;
      wr_nack_r <= 1'b0;
    end else begin
      wr_ack_r <= wr_take;
      wr_nack_r <= wr_refuse;
    end
  end

  // Sticky communication flags; a new refusal in the clear cycle keeps the flag set.
  logic cml_flag_r;
  logic ivd_flag_r;
  wire logic cml_flag_nxt = wr_refuse | (cml_flag_r & ~i_cml_clr);
  wire logic ivd_flag_nxt = wr_refuse | (ivd_flag_r & ~i_cml_clr);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cml_flag_r <= 1'b0;
      ivd_flag_r <= 1'b0;
    end else begin
      cml_flag_r <= cml_flag_nxt;
      ivd_flag_r <= ivd_flag_nxt;
    end
  end

  // Read path.
  wire logic [8:0] stack_amps = 9'(ocw_amps(ocw_lvl) * i_stack_number);
  wire logic rd_hit = i_rd_stb & (is_ocw | is_ot);
  wire logic rd_bcast_ocw = is_ocw & bcast;
  wire logic rd_quiet = rd_hit & rd_bcast_ocw & ~i_primary;
  wire logic rd_answer = rd_hit & ~rd_quiet;

  wire logic [15:0] ocw_word = {OCW_EXP, RSV_VAL, ocw_code_r};
  wire logic [15:0] ocw_bcast_word = {OCW_EXP, 2'b00, stack_amps};
  wire logic [15:0] ot_word = {OT_EXP, RSV_VAL, ot_code_r};
  wire logic [15:0] rd_word = is_ot ? ot_word : (rd_bcast_ocw ? ocw_bcast_word : ocw_word);

  logic rd_valid_r;
  logic rd_silent_r;
  logic [15:0] rd_data_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_valid_r <= 1'b0;
      rd_silent_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      rd_valid_r <= rd_answer;
      rd_silent_r <= rd_quiet;
      if (rd_answer) begin
        rd_data_r <= rd_word;
      end
    end
  end

  // Thresholds in physical units.
  wire logic [5:0] ocw_thr = ocw_amps(ocw_lvl);
  wire logic [7:0] ot_thr = OT_DEGC[ot_lvl];

  // Comparators are registered so the warn and fault outputs never glitch on a threshold change.
  wire logic ocw_warn_nxt = (i_iout_avg > IOUT_W'(ocw_thr));
  wire logic ot_fault_nxt = (i_die_temp >= TEMP_W'(ot_thr));

  logic ocw_warn_r;
  logic ot_fault_r;
  logic temp_flag_r;
  wire logic temp_flag_nxt = ot_fault_r | (temp_flag_r & ~i_temp_flag_clr);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ocw_warn_r <= 1'b0;
      ot_fault_r <= 1'b0;
      temp_flag_r <= 1'b0;
    end else begin
      ocw_warn_r <= ocw_warn_nxt;
      ot_fault_r <= ot_fault_nxt;
      temp_flag_r <= temp_flag_nxt;
    end
  end

  // Threshold outputs are registered copies so they only move a cycle after the stored code.
  logic [5:0] ocw_amps_r;
  logic [7:0] ot_degc_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ocw_amps_r <= 6'h00;
      ot_degc_r <= 8'h00;
    end else begin
      ocw_amps_r <= ocw_thr;
      ot_degc_r <= ot_thr;
    end
  end

  assign o_wr_ack = wr_ack_r;
  assign o_wr_nack = wr_nack_r;
  assign o_rd_valid = rd_valid_r;
  assign o_rd_silent = rd_silent_r;
  assign o_rd_data = rd_data_r;
  assign o_ocw_amps = ocw_amps_r;
  assign o_ot_degc = ot_degc_r;
  assign o_ocw_warn = ocw_warn_r;
  assign o_ot_fault = ot_fault_r;
  assign o_cml_flag = cml_flag_r;
  assign o_ivd_flag = ivd_flag_r;
  assign o_temp_fault_flag = temp_flag_r;
  // Alert is a level that stays up while any sticky flag is set.
  assign o_alert = temp_flag_r | cml_flag_r;

endmodule // limit_regs

// >>> dv/limit_regs_assertions.sv
// Port-level checker for the limit register block.
`timescale 1ns/1ps
module limit_regs_assertions #(
  parameter int IOUT_W = 8,
  parameter int TEMP_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_phase,
  input wire logic [15:0] i_wr_data,
  input wire logic i_primary,
  input wire logic [IOUT_W-1:0] i_iout_avg,
  input wire logic [TEMP_W-1:0] i_die_temp,
  input wire logic o_wr_ack,
  input wire logic o_wr_nack,
  input wire logic o_rd_valid,
  input wire logic o_rd_silent,
  input wire logic [15:0] o_rd_data,
  input wire logic [5:0] o_ocw_amps,
  input wire logic [7:0] o_ot_degc,
  input wire logic o_ocw_warn,
  input wire logic o_ot_fault,
  input wire logic o_cml_flag,
  input wire logic o_ivd_flag,
  input wire logic o_temp_fault_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wr_nack_a: assert property (
    i_wr_stb && i_cmd == 8'h4A && i_phase != 8'hFF && i_wr_data[15:6] != 10'h000 |=> o_wr_nack && !o_wr_ack)
    else $error("bad current write not refused");
  ot_nack_a: assert property (
    i_wr_stb && i_cmd == 8'h4F && i_wr_data[15:6] != 10'h040 |=> o_wr_nack && !o_wr_ack)
    else $error("bad temperature write not refused");
  nack_flags_a: assert property (o_wr_nack |-> o_cml_flag && o_ivd_flag)
    else $error("refusal without flags");
  ot_read_a: assert property (
    i_rd_stb && i_cmd == 8'h4F |=> o_rd_valid && o_rd_data[15:6] == 10'h040)
    else $error("temperature read fixed bits wrong");
  ocw_read_a: assert property (
    i_rd_stb && i_cmd == 8'h4A && i_phase != 8'hFF |=> o_rd_valid && o_rd_data[15:6] == 10'h000)
    else $error("current read fixed bits wrong");
  warn_cmp_a: assert property (
    $past(!i_rst) |-> o_ocw_warn == ($past(i_iout_avg) > o_ocw_amps))
    else $error("current warning compare wrong");
  fault_cmp_a: assert property (
    $past(!i_rst) |-> o_ot_fault == ($past(i_die_temp) >= o_ot_degc))
    else $error("temperature fault compare wrong");
  tflag_a: assert property (o_ot_fault |=> o_temp_fault_flag)
    else $error("fault flag not set");
  silent_a: assert property (
    i_rd_stb && i_cmd == 8'h4A && i_phase == 8'hFF && !i_primary |=> o_rd_silent && !o_rd_valid)
    else $error("non-primary answered broadcast read");
  nack_c: cover property (o_wr_nack);
  silent_c: cover property (o_rd_silent);
  tflag_c: cover property ($rose(o_temp_fault_flag));
endmodule // limit_regs_assertions

// >>> dv/host_model.sv
// Host model issuing single word writes and reads.
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk,
  input wire logic i_wr_ack,
  input wire logic i_wr_nack,
  input wire logic i_rd_valid,
  input wire logic i_rd_silent,
  input wire logic [15:0] i_rd_data,
  output logic o_wr_stb = 1'b0,
  output logic o_rd_stb = 1'b0,
  output logic [7:0] o_cmd = 8'h00,
  output logic [7:0] o_phase = 8'h00,
  output logic [15:0] o_data = 16'h0000
);
  // Fields are inverted after the taking edge so a design reading them late sees wrong values.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p, input logic [15:0] d,
                      output logic [17:0] r);
    @(posedge i_clk);
    o_cmd <= c;
    o_phase <= p;
    o_data <= d;
    o_wr_stb <= w;
    o_rd_stb <= !w;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b0;
    o_cmd <= ~c;
    o_phase <= ~p;
    o_data <= ~d;
    @(posedge i_clk);
    r = w ? {i_wr_ack, i_wr_nack, 16'h0000} : {i_rd_valid, i_rd_silent, i_rd_data};
  endtask
endmodule // host_model

// >>> dv/current_temp_limit_registers_test.sv
// Self-checking bench for the limit register block.
`timescale 1ns/1ps
module current_temp_limit_registers_test;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr_stb, i_rd_stb, i_primary = 1'b1, i_nvm_load = 1'b0;
  logic i_cml_clr = 1'b0, i_temp_flag_clr = 1'b0;
  logic [7:0] i_cmd, i_phase, i_iout_avg = 8'h00, i_die_temp = 8'h00, o_ot_degc;
  logic [15:0] i_wr_data, o_rd_data;
  logic [2:0] i_stack_number = 3'h1, i_nvm_ot_level = 3'h0;
  logic [3:0] i_nvm_ocw_level = 4'h0;
  logic o_wr_ack, o_wr_nack, o_rd_valid, o_rd_silent, o_ocw_warn, o_ot_fault;
  logic o_cml_flag, o_ivd_flag, o_temp_fault_flag, o_alert;
  logic [5:0] o_ocw_amps;
  logic [17:0] r;
  int n_errors = 0, n_compared = 0, cycles = 0, seed = 32'hC20B, v, vt, d, st, e;
  int corner [6] = '{0, 7, 8, 52, 53, 63};
  int ot_code [8] = '{29, 30, 31, 32, 34, 35, 36, 37};
  limit_regs limit_regs_i (.i_clk(i_clk), .i_rst(i_rst), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_cmd(i_cmd),
    .i_phase(i_phase), .i_wr_data(i_wr_data), .i_stack_number(i_stack_number), .i_primary(i_primary),
    .i_nvm_load(i_nvm_load), .i_nvm_ocw_level(i_nvm_ocw_level), .i_nvm_ot_level(i_nvm_ot_level),
    .i_cml_clr(i_cml_clr), .i_temp_flag_clr(i_temp_flag_clr), .i_iout_avg(i_iout_avg), .i_die_temp(i_die_temp),
    .o_wr_ack(o_wr_ack), .o_wr_nack(o_wr_nack), .o_rd_valid(o_rd_valid), .o_rd_silent(o_rd_silent),
    .o_rd_data(o_rd_data), .o_ocw_amps(o_ocw_amps), .o_ot_degc(o_ot_degc), .o_ocw_warn(o_ocw_warn),
    .o_ot_fault(o_ot_fault), .o_cml_flag(o_cml_flag), .o_ivd_flag(o_ivd_flag),
    .o_temp_fault_flag(o_temp_fault_flag), .o_alert(o_alert));
  host_model host_model_i (.i_clk(i_clk), .i_wr_ack(o_wr_ack), .i_wr_nack(o_wr_nack), .i_rd_valid(o_rd_valid),
    .i_rd_silent(o_rd_silent), .i_rd_data(o_rd_data), .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb), .o_cmd(i_cmd),
    .o_phase(i_phase), .o_data(i_wr_data));
  always #2.5 i_clk = ~i_clk;
  function automatic int ocw_x(input int c);
    return c < 8 ? 5 : c >= 53 ? 55 : 5 * ((c - 8) / 5 + 2);
  endfunction
  function automatic int tri_x(input int c);
    return c < 23 ? 5 : c >= 158 ? 55 : 5 * ((c - 23) / 15 + 2);
  endfunction
  function automatic int ot_x(input int c);
    return c < 30 ? 115 : c >= 37 ? 150 : c < 32 ? 120 + 5 * (c - 30) : c < 34 ? 130 : 135 + 5 * (c - 34);
  endfunction
  task automatic chk(input string nm, input logic [17:0] s, input logic [17:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // The whole run needs under a thousand cycles; the ceiling leaves wide margin.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
    chk("ocw rst", r, 18'h2001E);
    host_model_i.xfer(0, 8'h4F, 8'h00, 16'h0000, r);
    chk("ot rst", r, 18'h21024);
    chk("rst lvl", {o_ocw_amps, o_ot_degc}, {6'd30, 8'd145});
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      v = i < 6 ? corner[i] : $random(seed) & 63;
      vt = i < 9 ? 29 + i : $random(seed) & 63;
      host_model_i.xfer(1, 8'h4A, 8'h00, 16'(v), r);
      chk("ocw ack", r[17:16], 2'b10);
      host_model_i.xfer(1, 8'h4F, 8'h00, 16'h1000 | 16'(vt), r);
      chk("ot ack", r[17:16], 2'b10);
      host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
      chk("ocw rd", r[15:0], 16'(v));
      host_model_i.xfer(0, 8'h4F, 8'h00, 16'h0000, r);
      chk("ot rd", r[15:0], 16'h1000 | 16'(vt));
      chk("ocw lvl", o_ocw_amps, 18'(ocw_x(v)));
      chk("ot lvl", o_ot_degc, 18'(ot_x(vt)));
      i_iout_avg <= 8'(ocw_x(v) - 1 + ($random(seed) & 3));
      i_die_temp <= 8'(ot_x(vt) - 1 + ($random(seed) & 3));
      repeat (2) @(posedge i_clk);
      chk("warn", o_ocw_warn, 18'(i_iout_avg > ocw_x(v)));
      chk("fault", o_ot_fault, 18'(i_die_temp >= ot_x(vt)));
    end
    $display("test plain done");
    host_model_i.xfer(1, 8'h4A, 8'h00, 16'h0040 | 16'(v), r);
    chk("ocw ro", r[17:16], 2'b01);
    chk("flags", {o_cml_flag, o_ivd_flag, o_alert}, 3'b111);
    host_model_i.xfer(1, 8'h4F, 8'h00, 16'h0800 | 16'(vt), r);
    chk("ot ro", r[17:16], 2'b01);
    host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
    chk("ocw kept", r[15:0], 16'(v));
    host_model_i.xfer(0, 8'h4F, 8'h00, 16'h0000, r);
    chk("ot kept", r[15:0], 16'h1000 | 16'(vt));
    i_die_temp <= 8'hFF;
    repeat (3) @(posedge i_clk);
    chk("tflag", {o_ot_fault, o_temp_fault_flag, o_alert}, 3'b111);
    i_die_temp <= 8'h00;
    repeat (2) @(posedge i_clk);
    i_cml_clr <= 1'b1;
    i_temp_flag_clr <= 1'b1;
    @(posedge i_clk);
    i_cml_clr <= 1'b0;
    i_temp_flag_clr <= 1'b0;
    @(posedge i_clk);
    chk("clr", {o_cml_flag, o_ivd_flag, o_temp_fault_flag, o_alert}, 4'h0);
    $display("test refuse done");
    for (int i = 0; i < 15; i++) begin
      st = 2 + i % 3;
      d = i < 3 ? 0 : $random(seed) & (st == 3 ? 255 : 2047);
      e = st == 3 ? tri_x(d) : ocw_x((d + st / 2) >> (st / 2));
      i_stack_number <= 3'(st);
      i_primary <= 1'b1;
      host_model_i.xfer(1, 8'h4A, 8'hFF, 16'(d), r);
      chk("bc ack", r[17:16], 2'b10);
      host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
      chk("bc code", r[15:0], 16'(e));
      host_model_i.xfer(0, 8'h4A, 8'hFF, 16'h0000, r);
      chk("bc rd", r, {2'b10, 16'(e * st)});
      i_primary <= 1'b0;
      host_model_i.xfer(0, 8'h4A, 8'hFF, 16'h0000, r);
      chk("bc quiet", r[17:16], 2'b01);
    end
    host_model_i.xfer(1, 8'h4A, 8'hFF, 16'h0800, r);
    chk("bc ro", r[17:16], 2'b01);
    // A single-phase stack treats a broadcast write as a plain one.
    i_stack_number <= 3'h1;
    host_model_i.xfer(1, 8'h4A, 8'hFF, 16'h002A, r);
    chk("bc one", r[17:16], 2'b10);
    host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
    chk("bc one rd", r[15:0], 16'h002A);
    $display("test broadcast done");
    for (int i = 0; i < 11; i++) begin
      i_nvm_ocw_level <= 4'(i);
      i_nvm_ot_level <= 3'(i);
      i_nvm_load <= 1'b1;
      @(posedge i_clk);
      i_nvm_load <= 1'b0;
      host_model_i.xfer(0, 8'h4A, 8'h00, 16'h0000, r);
      chk("nvm ocw", r[15:0], 16'(5 * (i + 1)));
      host_model_i.xfer(0, 8'h4F, 8'h00, 16'h0000, r);
      chk("nvm ot", r[15:0], 16'h1000 | 16'(ot_code[i % 8]));
    end
    $display("test restore done");
    complete_run();
  end
endmodule // current_temp_limit_registers_test
bind limit_regs limit_regs_assertions #(.IOUT_W(IOUT_W), .TEMP_W(TEMP_W)) limit_regs_assertions_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_cmd(i_cmd), .i_phase(i_phase),
  .i_wr_data(i_wr_data), .i_primary(i_primary), .i_iout_avg(i_iout_avg), .i_die_temp(i_die_temp),
  .o_wr_ack(o_wr_ack), .o_wr_nack(o_wr_nack), .o_rd_valid(o_rd_valid), .o_rd_silent(o_rd_silent),
  .o_rd_data(o_rd_data), .o_ocw_amps(o_ocw_amps), .o_ot_degc(o_ot_degc), .o_ocw_warn(o_ocw_warn),
  .o_ot_fault(o_ot_fault), .o_cml_flag(o_cml_flag), .o_ivd_flag(o_ivd_flag),
  .o_temp_fault_flag(o_temp_fault_flag));
